// *** hdl/pse_ptp_servo.sv ***
// ptp offset reporting, servo lock tracking and periodic timestamp event generator
module pse_ptp_servo #(
  parameter int unsigned LOCK_SAMPLES = pse_pkg::LOCK_SAMPLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [63:0] master_offset_value,
  input  wire logic        offset_stb,
  input  wire logic [3:0]  last_port_event,
  input  wire logic        port_event_stb,
  input  wire logic [1:0]  sync_transport_kind,
  output logic [63:0]      servo_correction,
  output logic             servo_step,
  output logic             periodic_event,
  output logic             frame_start,
  output logic             irq
);

  logic                      aw_have_q, awready_q, w_have_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0]                aw_addr_q;
  logic [31:0]               wdata_q, rdata_q, rd_mux;
  logic [3:0]                wstrb_q;
  logic [1:0]                bresp_q, rresp_q;
  logic                      do_wr, ar_hs, rd_ok, wr_ok;
  logic                      en_q;
  logic [2:0]                lim_sel_q;
  logic [31:0]               interval_q, rate;
  logic [63:0]               begin_q, begin_new, used_q, next_q, ts_q, off_q, corr_q, off_abs;
  logic [31:0]               off_hi_snap_q;
  logic [3:0]                mask_q, sts_q, ev_set;
  logic                      irq_q, step_q, evt_q, frame_q;
  logic                      armed_q, catch_q, fr_pend_q, rate_go_q, arm;
  logic                      over, step_fire, evt_fire, frame_fire;
  logic [7:0]                lock_cnt_q;
  pse_pkg::pse_servo_t       srv_q;
  pse_pkg::pse_port_event_t  last_ev_q;
  logic [1:0]                xport_q;

  // write path: address and data are taken independently, answered once both are in
  assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
  assign arm   = do_wr & (aw_addr_q == pse_pkg::A_BEGIN_HI);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid & awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end else begin
      awready_q <= ~aw_have_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid & wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end else begin
      wready_q <= ~w_have_q;
    end
  end

  // read-only and unmapped offsets answer slverr and change nothing
  always_comb begin
    unique case (aw_addr_q)
      pse_pkg::A_CTRL, pse_pkg::A_INTERVAL, pse_pkg::A_BEGIN_LO,
      pse_pkg::A_BEGIN_HI, pse_pkg::A_INT_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pse_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? pse_pkg::RESP_OKAY : pse_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // settings; an out-of-range limit code keeps the previous setting
  // limit choice only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q       <= 1'b0;
      lim_sel_q  <= pse_pkg::LIM_SEL_RST;
      interval_q <= pse_pkg::INTERVAL_RST;
      begin_q    <= 64'h0;
      mask_q     <= pse_pkg::MASK_RST;
    end else if (do_wr) begin
      if (aw_addr_q == pse_pkg::A_CTRL) begin
        if (wstrb_q[0]) begin
          en_q <= wdata_q[pse_pkg::CTRL_EN_BIT];
        end
        if (wstrb_q[1] && wdata_q[pse_pkg::CTRL_LIM_LSB +: 3] <= pse_pkg::LIM_SEL_MAX) begin
          lim_sel_q <= wdata_q[pse_pkg::CTRL_LIM_LSB +: 3];
        end
      end
      if (aw_addr_q == pse_pkg::A_INTERVAL) begin
        interval_q <= pse_pkg::merge(interval_q, wdata_q, wstrb_q);
      end
      if (aw_addr_q == pse_pkg::A_BEGIN_LO) begin
        begin_q[31:0] <= pse_pkg::merge(begin_q[31:0], wdata_q, wstrb_q);
      end
      if (arm) begin
        begin_q <= begin_new;
      end
      if (aw_addr_q == pse_pkg::A_INT_MASK) begin
        mask_q <= 4'(pse_pkg::merge({28'h0, mask_q}, wdata_q, wstrb_q));
      end
    end
  end

  assign begin_new = {pse_pkg::merge(begin_q[63:32], wdata_q, wstrb_q), begin_q[31:0]};

  // read path: one-cycle registered answer
  assign ar_hs = s_axi_arvalid & arready_q;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      pse_pkg::A_CTRL:     rd_mux = {21'h0, lim_sel_q, 7'h0, en_q};
      pse_pkg::A_STATUS:   rd_mux = {14'h0, xport_q, 4'h0, last_ev_q, 6'h0, srv_q};
      pse_pkg::A_OFF_LO:   rd_mux = off_q[31:0];
      pse_pkg::A_OFF_HI:   rd_mux = off_hi_snap_q;
      pse_pkg::A_INTERVAL: rd_mux = interval_q;
      pse_pkg::A_RATE:     rd_mux = rate;
      pse_pkg::A_BEGIN_LO: rd_mux = begin_q[31:0];
      pse_pkg::A_BEGIN_HI: rd_mux = begin_q[63:32];
      pse_pkg::A_USED_LO:  rd_mux = used_q[31:0];
      pse_pkg::A_USED_HI:  rd_mux = used_q[63:32];
      pse_pkg::A_INT_STS:  rd_mux = {28'h0, sts_q};
      pse_pkg::A_INT_MASK: rd_mux = {28'h0, mask_q};
      pse_pkg::A_TS_LO:    rd_mux = ts_q[31:0];
      pse_pkg::A_TS_HI:    rd_mux = ts_q[63:32];
      default:             rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= pse_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_ok ? pse_pkg::RESP_OKAY : pse_pkg::RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else begin
      arready_q <= ~rvalid_q;
    end
  end

  // low-word read freezes the high word so a 64-bit offset never tears
  // offset sampled from the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_q         <= 64'h0;
      off_hi_snap_q <= 32'h0;
    end else begin
      if (offset_stb) begin
        off_q <= master_offset_value;
      end
      if (ar_hs && s_axi_araddr == pse_pkg::A_OFF_LO) begin
        off_hi_snap_q <= off_q[63:32];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_ev_q <= pse_pkg::EV_NONE;
      xport_q   <= 2'h0;
    end else begin
      xport_q <= sync_transport_kind;
      if (port_event_stb) begin
        last_ev_q <= pse_pkg::pse_port_event_t'(last_port_event);
      end
    end
  end

  // servo: limit is looked up each sample, so a new setting acts on the next one
  assign off_abs   = master_offset_value[63] ? 64'(-master_offset_value) : master_offset_value;
  assign over      = off_abs > pse_pkg::limit_ns(lim_sel_q);
  assign step_fire = en_q & offset_stb & (srv_q == pse_pkg::SRV_LOCKED) & over;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srv_q      <= pse_pkg::SRV_NA;
      lock_cnt_q <= 8'h0;
    end else if (!en_q) begin
      srv_q      <= pse_pkg::SRV_NA;
      lock_cnt_q <= 8'h0;
    end else begin
      unique case (srv_q)
        pse_pkg::SRV_NA: srv_q <= pse_pkg::SRV_UNLOCKED;
        pse_pkg::SRV_UNLOCKED: if (offset_stb) begin
          srv_q      <= pse_pkg::SRV_SYNCING;
          lock_cnt_q <= 8'h0;
        end
        pse_pkg::SRV_SYNCING: if (offset_stb) begin
          if (over) begin
            lock_cnt_q <= 8'h0;
          end else if (lock_cnt_q == 8'(LOCK_SAMPLES - 1)) begin
            srv_q <= pse_pkg::SRV_LOCKED;
          end else begin
            lock_cnt_q <= lock_cnt_q + 8'h1;
          end
        end
        pse_pkg::SRV_LOCKED: if (step_fire) begin
          srv_q      <= pse_pkg::SRV_SYNCING;
          lock_cnt_q <= 8'h0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      corr_q <= 64'h0;
      step_q <= 1'b0;
    end else begin
      step_q <= step_fire;
      if (en_q & offset_stb) begin
        corr_q <= master_offset_value;
      end
    end
  end

  // free-running timestamp in ns; error per event stays within two clocks, well within 80 ns
  // timestamp base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_q <= 64'h0;
    end else begin
      ts_q <= ts_q + pse_pkg::TS_STEP_NS;
    end
  end

  // zero interval or unpassed begin time blocks the event
  assign evt_fire = armed_q & ~catch_q & ~arm & (interval_q != 32'h0) & (ts_q > next_q);

  // catch-up adds one interval per clock, so a far-past begin takes a while to settle
  // begin pushed forward
  // next event on the interval grid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      catch_q <= 1'b0;
      next_q  <= 64'h0;
      used_q  <= 64'h0;
    end else if (arm) begin
      armed_q <= 1'b1;
      catch_q <= (begin_new <= ts_q);
      next_q  <= begin_new;
      used_q  <= begin_new;
    end else if (armed_q && interval_q != 32'h0) begin
      if (catch_q) begin
        if (next_q <= ts_q) begin
          next_q <= next_q + 64'(interval_q);
        end else begin
          catch_q <= 1'b0;
          used_q  <= next_q;
        end
      end else if (evt_fire) begin
        next_q <= next_q + 64'(interval_q);
      end
    end
  end

  assign frame_fire = fr_pend_q & ~arm & (ts_q > begin_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr_pend_q <= 1'b0;
      frame_q   <= 1'b0;
      evt_q     <= 1'b0;
    end else begin
      frame_q <= frame_fire;
      evt_q   <= evt_fire;
      if (arm) begin
        fr_pend_q <= 1'b1;
      end else if (frame_fire) begin
        fr_pend_q <= 1'b0;
      end
    end
  end

  // rate recomputed after each interval write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_go_q <= 1'b0;
    end else begin
      rate_go_q <= do_wr & (aw_addr_q == pse_pkg::A_INTERVAL);
    end
  end

  pse_rate_div #(.W(32)) u_rate (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (rate_go_q),
    .divisor  (interval_q),
    .quotient (rate)
  );

  // sticky status, cleared by reading it; a coincident event wins over the clear
  always_comb begin
    ev_set                       = 4'h0;
    ev_set[pse_pkg::INT_PERIODIC] = evt_fire;
    ev_set[pse_pkg::INT_STEP]     = step_fire;
    ev_set[pse_pkg::INT_PORT]     = port_event_stb;
    ev_set[pse_pkg::INT_FRAME]    = frame_fire;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= ((ar_hs && s_axi_araddr == pse_pkg::A_INT_STS) ? 4'h0 : sts_q) | ev_set;
      irq_q <= |(sts_q & mask_q);
    end
  end

  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign servo_correction = corr_q;
  assign servo_step       = step_q;
  assign periodic_event   = evt_q;
  assign frame_start      = frame_q;
  assign irq              = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_zero_interval_off: assert property ((interval_q == 32'h0) |=> !periodic_event)
    else $error("periodic event with zero interval");
  a_event_after_begin: assert property ($rose(periodic_event) |-> $past(ts_q) > $past(next_q))
    else $error("periodic event before begin time passed");
  a_event_grid_step: assert property (periodic_event |-> next_q == $past(next_q) + 64'($past(interval_q)))
    else $error("next event not one interval later");
  a_step_unlocks: assert property ((en_q && offset_stb && srv_q == pse_pkg::SRV_LOCKED && over) |=>
    servo_step && srv_q == pse_pkg::SRV_SYNCING)
    else $error("servo stayed locked past limit");
  a_disabled_na: assert property (!en_q |=> srv_q == pse_pkg::SRV_NA)
    else $error("servo state not n/a when disabled");
  a_corr_follows: assert property ((en_q && offset_stb) |=> servo_correction == $past(master_offset_value))
    else $error("correction not taken from offset");
  a_last_event_kept: assert property (port_event_stb |=> last_ev_q == $past(last_port_event))
    else $error("last port event not recorded");
  a_limit_legal: assert property (lim_sel_q <= pse_pkg::LIM_SEL_MAX)
    else $error("illegal limit setting held");
  a_used_future: assert property ((armed_q && !catch_q && $changed(used_q)) |-> used_q > $past(ts_q))
    else $error("used begin time lies in the past");
  a_frame_once: assert property (frame_start |=> !frame_start [*2])
    else $error("frame start repeated");

endmodule

// *** hdl/pse_pkg.sv ***
// shared constants, types and helpers for the ptp servo and periodic event block
package pse_pkg;

  // clock and timestamp
  localparam int unsigned  CLK_PERIOD_NS = 10;
  localparam logic [63:0]  TS_STEP_NS    = 64'(CLK_PERIOD_NS);
  localparam int unsigned  EVT_RES_NS    = 80;
  localparam logic [31:0]  NS_PER_S      = 32'h3b9aca00;
  localparam logic [63:0]  NS_PER_US     = 64'h0000_0000_0000_03e8;
  localparam int unsigned  LOCK_SAMPLES  = 4;

  // register byte offsets
  localparam logic [7:0]   A_CTRL        = 8'h00;
  localparam logic [7:0]   A_STATUS      = 8'h04;
  localparam logic [7:0]   A_OFF_LO      = 8'h08;
  localparam logic [7:0]   A_OFF_HI      = 8'h0c;
  localparam logic [7:0]   A_INTERVAL    = 8'h10;
  localparam logic [7:0]   A_RATE        = 8'h14;
  localparam logic [7:0]   A_BEGIN_LO    = 8'h18;
  localparam logic [7:0]   A_BEGIN_HI    = 8'h1c;
  localparam logic [7:0]   A_USED_LO     = 8'h20;
  localparam logic [7:0]   A_USED_HI     = 8'h24;
  localparam logic [7:0]   A_INT_STS     = 8'h28;
  localparam logic [7:0]   A_INT_MASK    = 8'h2c;
  localparam logic [7:0]   A_TS_LO       = 8'h30;
  localparam logic [7:0]   A_TS_HI       = 8'h34;

  // field positions
  localparam int unsigned  CTRL_EN_BIT   = 0;
  localparam int unsigned  CTRL_LIM_LSB  = 8;
  localparam int unsigned  ST_SERVO_LSB  = 0;
  localparam int unsigned  ST_EVENT_LSB  = 8;
  localparam int unsigned  ST_XPORT_LSB  = 16;
  localparam int unsigned  INT_W         = 4;
  localparam int unsigned  INT_PERIODIC  = 0;
  localparam int unsigned  INT_STEP      = 1;
  localparam int unsigned  INT_PORT      = 2;
  localparam int unsigned  INT_FRAME     = 3;

  // reset values and the largest legal limit code
  localparam logic [2:0]   LIM_SEL_RST   = 3'h0;
  localparam logic [2:0]   LIM_SEL_MAX   = 3'h5;
  localparam logic [31:0]  INTERVAL_RST  = 32'h0;
  localparam logic [3:0]   MASK_RST      = 4'h0;

  localparam logic [1:0]   RESP_OKAY     = 2'h0;
  localparam logic [1:0]   RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    SRV_UNLOCKED, SRV_SYNCING, SRV_LOCKED, SRV_NA
  } pse_servo_t;

  typedef enum logic [3:0] {
    EV_NONE, EV_POWER_UP, EV_INITIALIZE, EV_DESIGNATION_ON, EV_DESIGNATION_OFF,
    EV_FAULT_CLEARED, EV_FAULT_DETECTED, EV_STATE_CHOICE_EVENT, EV_QUALIFY_TIMEOUT,
    EV_ANNOUNCE_TIMEOUT, EV_SYNC_FAULT, EV_MASTER_CHOSEN, EV_ADVISE_MASTER,
    EV_ADVISE_TOP_MASTER, EV_ADVISE_FOLLOWER, EV_ADVISE_PASSIVE
  } pse_port_event_t;

  // step limit in ns for each selectable microsecond setting
  function automatic logic [63:0] limit_ns(input logic [2:0] sel);
    logic [63:0] us;
    us = 64'h0;
    unique case (sel)
      3'h0: us = 64'd10;
      3'h1: us = 64'd20;
      3'h2: us = 64'd100;
      3'h3: us = 64'd500;
      3'h4: us = 64'd1000;
      default: us = 64'd2000;
    endcase
    return 64'(us * NS_PER_US);
  endfunction

  // byte-lane merge of a bus write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** hdl/pse_rate_div.sv ***
// serial divider turning the event interval in ns into an event rate in hz
module pse_rate_div #(
  parameter int unsigned W = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         start,
  input  wire logic [W-1:0] divisor,
  output logic      [W-1:0] quotient
);

  logic [W-1:0]  rem_q;
  logic [W-1:0]  quo_q;
  logic [W-1:0]  div_q;
  logic [W-1:0]  res_q;
  logic [5:0]    cnt_q;
  logic          busy_q;
  logic [W:0]    shifted;
  logic [W:0]    trial;

  // one restoring step per clock
  always_comb begin
    shifted = {rem_q, quo_q[W-1]};
    trial   = shifted - {1'b0, div_q};
  end

  // a zero divisor means the generator is off, so the rate reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_q  <= '0;
      quo_q  <= '0;
      div_q  <= '0;
      res_q  <= '0;
      cnt_q  <= 6'h0;
      busy_q <= 1'b0;
    end else if (start) begin
      rem_q  <= '0;
      quo_q  <= W'(pse_pkg::NS_PER_S);
      div_q  <= divisor;
      cnt_q  <= 6'(W);
      busy_q <= (divisor != '0);
      if (divisor == '0) begin
        res_q <= '0;
      end
    end else if (busy_q) begin
      if (!trial[W]) begin
        rem_q <= trial[W-1:0];
        quo_q <= {quo_q[W-2:0], 1'b1};
      end else begin
        rem_q <= shifted[W-1:0];
        quo_q <= {quo_q[W-2:0], 1'b0};
      end
      cnt_q <= cnt_q - 6'h1;
      if (cnt_q == 6'h1) begin
        busy_q <= 1'b0;
        res_q  <= {quo_q[W-2:0], ~trial[W]};
      end
    end
  end

  assign quotient = res_q;

endmodule

// *** verif/pse_master_model.sv ***
// behavioural time master feeding offset samples and port events
module pse_master_model (
  input  wire logic        aclk,
  input  wire logic        off_req,
  input  wire logic [63:0] off_val,
  input  wire logic        ev_req,
  input  wire logic [3:0]  ev_code,
  input  wire logic [1:0]  xport,
  output logic      [63:0] master_offset_value,
  output logic             offset_stb,
  output logic      [3:0]  last_port_event,
  output logic             port_event_stb,
  output logic      [1:0]  sync_transport_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {master_offset_value, offset_stb, last_port_event, port_event_stb, sync_transport_kind} = '0;
  end
  // payload only valid with its strobe; inverted otherwise so a stale sample never looks fresh
  always @(posedge aclk) begin
    offset_stb          <= off_req;
    master_offset_value <= off_req ? off_val : ~master_offset_value;
    port_event_stb      <= ev_req;
    last_port_event     <= ev_req ? ev_code : ~last_port_event;
    sync_transport_kind <= xport;
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the servo and periodic event block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LS = 2;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic off_req = 0, ev_req = 0;
  logic [63:0] off_val = 0, mov, corr;
  logic [3:0] ev_code = 0, lpe;
  logic [1:0] xport = 0, stk, bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, ostb, pstb, sstep, pev, fst, irq;
  logic [31:0] rdata;
  int num_errors = 0, n_tests = 0, cyc = 0, n_ev = 0, n_step = 0, n_fr = 0, last_ev = 0, gap = 0, ev_at_fr = 9;
  int unsigned iv, ts, bg, lim, k;

  pse_ptp_servo #(.LOCK_SAMPLES(LS)) pse_ptp_servo_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .master_offset_value(mov), .offset_stb(ostb), .last_port_event(lpe),
    .port_event_stb(pstb), .sync_transport_kind(stk), .servo_correction(corr), .servo_step(sstep),
    .periodic_event(pev), .frame_start(fst), .irq(irq));
  pse_master_model pse_master_model_i (.aclk(aclk), .off_req(off_req), .off_val(off_val), .ev_req(ev_req),
    .ev_code(ev_code), .xport(xport), .master_offset_value(mov), .offset_stb(ostb), .last_port_event(lpe),
    .port_event_stb(pstb), .sync_transport_kind(stk));

  initial begin
    forever #5 aclk = ~aclk;
  end

  // pulse bookkeeping on the falling edge, so counts never race the stimulus edge
  // the frame check runs first so a same-cycle event still counts as not early
  always @(negedge aclk) begin
    cyc++;
    if (fst) begin n_fr++; ev_at_fr = n_ev; end
    if (pev) begin gap = cyc - last_ev; last_ev = cyc; n_ev++; end
    if (sstep) n_step++;
  end

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end
  endtask

  // ready sampled at the edge, so valid drops only once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    if (i == 50) begin num_errors++; summarize(); end
  endtask

  task automatic rdr(input logic [7:0] a);
    int i;
    araddr <= a; arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata; rs = rresp;
    if (i == 50) begin num_errors++; summarize(); end
  endtask

  task automatic snd(input logic [63:0] v);
    off_val <= v; off_req <= 1'b1;
    @(posedge aclk) off_req <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  function automatic int unsigned lim_ns(input int s);
    int unsigned t[6] = '{10, 20, 100, 500, 1000, 2000};
    return t[s] * 1000;
  endfunction

  // main sequence
  initial begin
    void'($urandom(94457));
    repeat (12) @(posedge aclk);
    aresetn <= 1; bready <= 1; rready <= 1;
    repeat (2) @(posedge aclk);
    rdr(pse_pkg::A_CTRL); chk("ctrl", rd, 0);
    rdr(pse_pkg::A_STATUS); chk("servo na", rd[1:0], 3);
    rdr(8'h3c); chk("unmapped", {rs, rd}, 34'h200000000);
    wr(pse_pkg::A_RATE, 32'h1, rs); chk("ro write", rs, pse_pkg::RESP_SLVERR);
    for (int c = 0; c < 16; c++) begin
      ev_code <= 4'(c); xport <= 2'($urandom); ev_req <= 1'b1;
      @(posedge aclk) ev_req <= 1'b0;
      repeat (3) @(posedge aclk);
      rdr(pse_pkg::A_STATUS);
      chk("event", rd[11:8], c);
      chk("xport", rd[17:16], xport);
    end
    off_val = {$urandom, $urandom};
    snd(off_val); rdr(pse_pkg::A_OFF_LO); chk("off lo", rd, off_val[31:0]);
    rdr(pse_pkg::A_OFF_HI); chk("off hi", rd, off_val[63:32]);
    wr(pse_pkg::A_INT_MASK, 32'h2, rs);
    for (int s = 0; s < 6; s++) begin
      wr(pse_pkg::A_CTRL, 32'(s << 8) | 32'h1, rs);
      lim = lim_ns(s); k = n_step;
      repeat (LS + 1) snd(0);
      rdr(pse_pkg::A_STATUS); chk("locked", rd[1:0], 2);
      snd(64'(lim)); chk("at limit", n_step, k);
      snd(-64'(lim + 1)); chk("step", n_step, k + 1);
      chk("corr", corr, -64'(lim + 1));
      rdr(pse_pkg::A_STATUS); chk("syncing", rd[1:0], 1);
    end
    chk("irq on", irq, 1);
    wr(pse_pkg::A_CTRL, 32'h701, rs); rdr(pse_pkg::A_CTRL); chk("bad sel", rd, 32'h501);
    rdr(pse_pkg::A_INT_STS); chk("sts", rd[1], 1);
    repeat (3) @(posedge aclk); chk("irq off", irq, 0);
    rdr(pse_pkg::A_RATE); chk("rate 0", rd, 0);
    chk("no ev", n_ev, 0);
    iv = 10 * $urandom_range(50, 150);
    wr(pse_pkg::A_INTERVAL, iv, rs);
    rdr(pse_pkg::A_TS_LO); bg = rd + 3000;
    wr(pse_pkg::A_BEGIN_LO, bg, rs); wr(pse_pkg::A_BEGIN_HI, 0, rs);
    repeat (40) @(posedge aclk);
    rdr(pse_pkg::A_RATE); chk("rate", rd, 1000000000 / iv);
    rdr(pse_pkg::A_USED_LO); chk("used", rd, bg);
    for (k = 0; k < 3000 && n_ev < 4; k++) @(posedge aclk);
    if (k == 3000) begin num_errors++; summarize(); end
    chk("first ev", ev_at_fr, 0);
    chk("frame", n_fr, 1);
    chk("gap", gap, iv / 10);
    // begin time in the past: used value pushed forward by whole intervals
    wr(pse_pkg::A_BEGIN_LO, 0, rs); wr(pse_pkg::A_BEGIN_HI, 0, rs);
    rdr(pse_pkg::A_TS_LO); ts = rd;
    repeat (400) @(posedge aclk);
    rdr(pse_pkg::A_USED_LO); chk("past", (rd % iv == 0) && (rd > ts), 1);
    wr(pse_pkg::A_INTERVAL, 0, rs); k = n_ev;
    repeat (3 * iv / 10) @(posedge aclk); chk("stopped", n_ev, k);
    summarize();
  end
endmodule
